// File: logic/gpd_pkg.sv
/*
   Constants for the GPIO drive/direction register core: register byte
   offsets, reset values and widths. Assumes a 32-bit APB host.
*/
package gpd_pkg;
   localparam int unsigned PIN_COUNT = 32;
   localparam int unsigned ADDR_W = 12;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_DRIVE_LEVEL = 12'h504;
   localparam logic [11:0] OFF_DRIVE_SET = 12'h508;
   localparam logic [11:0] OFF_DRIVE_CLEAR = 12'h50C;
   localparam logic [11:0] OFF_PORT_LEVEL_READ = 12'h510;
   localparam logic [11:0] OFF_PORT_ORIENTATION = 12'h514;
   localparam logic [11:0] OFF_ORIENTATION_SET = 12'h518;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_DRIVE_LEVEL = 32'h0000_0000;
   localparam logic [31:0] RST_PORT_ORIENTATION = 32'h0000_0000;
   localparam logic [31:0] RST_PORT_LEVEL_READ = 32'h0000_0000;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
   // Register select decode
   typedef enum {
      SEL_NONE,
      SEL_DRIVE_LEVEL,
      SEL_DRIVE_SET,
      SEL_DRIVE_CLEAR,
      SEL_LEVEL_READ,
      SEL_ORIENT,
      SEL_ORIENT_SET
   } gpd_sel_t;
endpackage : gpd_pkg

// File: logic/gpd_port.sv
/*
   GPIO port drive/direction register core with an APB slave.
   Holds the drive latch with set/clear aliases, the orientation latch
   with a set alias, and a synchronised view of the pin levels.
   Assumes an APB master on CLK and pad cells taking per-pin data and an
   active-low output enable; input buffer gating lives outside.
*/
// How it works
// - Drive bit sets pin output level
// - Set alias ORs written ones in
// - Clear alias clears written-one bits
// - Drive alias reads return drive register
// - Level read shows synchronised pin inputs
// - Orientation bit one makes pin output
// - Orientation set alias ORs ones in
// - Orientation set reads orientation register
module gpd_port
   import gpd_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [PIN_COUNT-1:0] PIN_IN,
   output logic [PIN_COUNT-1:0] PIN_OUT,
   output logic [PIN_COUNT-1:0] PIN_OE_N
);
   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic gpd_sel_t decode(input logic [ADDR_W-1:0] a);
      unique case (a)
         OFF_DRIVE_LEVEL: decode = SEL_DRIVE_LEVEL;
         OFF_DRIVE_SET: decode = SEL_DRIVE_SET;
         OFF_DRIVE_CLEAR: decode = SEL_DRIVE_CLEAR;
         OFF_PORT_LEVEL_READ: decode = SEL_LEVEL_READ;
         OFF_PORT_ORIENTATION: decode = SEL_ORIENT;
         OFF_ORIENTATION_SET: decode = SEL_ORIENT_SET;
         default: decode = SEL_NONE;
      endcase
   endfunction : decode

   // ----------------------------------------------------------------
   // Lane merge and read selection
   // ----------------------------------------------------------------
   // Plain writes replace only the byte lanes that the strobes enable.
   // Both latches use this one helper so that their lane behaviour cannot
   // drift apart when one of them is changed later.
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
         input logic [31:0] data, input logic [31:0] mask);
      lane_merge = (old & ~mask) | (data & mask);
   endfunction : lane_merge

   // Read word per register: both drive aliases show the drive latch and
   // the orientation alias shows the orientation latch; no alias has
   // storage of its own, so a read can never disagree with the pins.
   function automatic logic [31:0] read_word(input gpd_sel_t s,
         input logic [31:0] drive, input logic [31:0] orient,
         input logic [31:0] level);
      unique case (s)
         SEL_DRIVE_LEVEL, SEL_DRIVE_SET, SEL_DRIVE_CLEAR: read_word = drive;
         SEL_LEVEL_READ: read_word = level;
         SEL_ORIENT, SEL_ORIENT_SET: read_word = orient;
         SEL_NONE: read_word = READ_UNMAPPED;
      endcase
   endfunction : read_word

   // ----------------------------------------------------------------
   // Bus qualifiers
   // ----------------------------------------------------------------
   // Decoded select and phase qualifiers, shared by the write side, the
   // read side and the assertions so that all three agree on a transfer
   gpd_sel_t sel;
   logic wr_en;
   logic rd_en;
   logic rd_setup;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [PIN_COUNT-1:0] pin_sync;

   assign sel = decode(PADDR);
   assign wr_en = PSEL & PENABLE & PWRITE;
   assign rd_en = PSEL & PENABLE & ~PWRITE;
   // Read data is captured at the end of the setup cycle, not the access
   assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
   // Byte strobes mask which lanes a write touches
   assign wmask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
   assign wbits = PWDATA & wmask;

   // Zero wait states: every access completes in its first access cycle.
   // This holds only because read data is fetched during setup; a slower
   // read path would need PREADY to be held low for the extra cycles.
   // A master that stretches setup retakes the snapshot on every setup cycle.
   assign PREADY = 1'b1;
   // Unmapped or read-only writes are ignored silently, never errored
   assign PSLVERR = 1'b0;

   // ----------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------
   // Two flops guard against metastability on the raw pins; the level
   // register adds one more edge, so software sees a pin change three
   // edges after it happens. Glitches shorter than a cycle may be missed.
   // Nothing but the second stage of the synchroniser reads the first.
   gpd_sync u_sync (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .D(PIN_IN),
      .Q(pin_sync)
   );

   // ----------------------------------------------------------------
   // Drive and orientation latches
   // ----------------------------------------------------------------
   // Drive and orientation latches hold software state; the level flop
   // is the last stage of the pin path and the read flop holds the word
   // that the current access returns.
   logic [31:0] drive_ff;
   logic [31:0] orient_ff;
   logic [31:0] level_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_drive;
   logic [31:0] nxt_orient;
   logic [31:0] nxt_level;
   logic [31:0] nxt_prdata;

   // Write side: plain writes merge by lane, aliases only touch ones.
   // Byte strobes gate the aliases too, so a narrow store to an alias
   // cannot clear or set pins in lanes that it did not address.
   // The level register is refreshed every cycle and ignores writes.
   always_comb begin
      nxt_drive = drive_ff;
      nxt_orient = orient_ff;
      nxt_level = pin_sync;
      if (wr_en) begin
         unique case (sel)
            SEL_DRIVE_LEVEL: nxt_drive = lane_merge(drive_ff, PWDATA, wmask);
            SEL_DRIVE_SET: nxt_drive = drive_ff | wbits;
            SEL_DRIVE_CLEAR: nxt_drive = drive_ff & ~wbits;
            SEL_ORIENT: nxt_orient = lane_merge(orient_ff, PWDATA, wmask);
            SEL_ORIENT_SET: nxt_orient = orient_ff | wbits;
            SEL_LEVEL_READ, SEL_NONE: ;
         endcase
      end
   end

   // Read side: registered so PRDATA comes from a flop; it is loaded in
   // the setup cycle, so data is valid during the single access cycle.
   // Taking the snapshot one cycle early is what lets PREADY stay high;
   // the cost is that read data is one cycle older than the access edge.
   always_comb begin
      nxt_prdata = prdata_ff;
      if (rd_setup) begin
         nxt_prdata = read_word(sel, drive_ff, orient_ff, level_ff);
      end
   end

   // All state shares one asynchronous reset to the documented zeros
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         drive_ff <= RST_DRIVE_LEVEL;
         orient_ff <= RST_PORT_ORIENTATION;
         level_ff <= RST_PORT_LEVEL_READ;
         prdata_ff <= READ_UNMAPPED;
      end else begin
         drive_ff <= nxt_drive;
         orient_ff <= nxt_orient;
         level_ff <= nxt_level;
         prdata_ff <= nxt_prdata;
      end
   end

   // ----------------------------------------------------------------
   // Pad drive
   // ----------------------------------------------------------------
   // Data follows the latch; enable is low only for output pins. Each pad
   // gets its own pair so that a per-pin override can later be spliced in
   // here without touching the register logic.
   for (genvar gi = 0; gi < PIN_COUNT; gi++) begin : g_pad
      // An input pin keeps its enable high whatever its drive bit holds
      assign PIN_OUT[gi] = drive_ff[gi];
      assign PIN_OE_N[gi] = ~orient_ff[gi];
   end
   // Read data leaves straight from its flop, with no logic behind it
   assign PRDATA = prdata_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Every property samples on CLK and rests while reset is high. The
   // aliases are checked both for full-word stores and for any strobe
   // pattern, since narrow stores are where lane gating can go wrong.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   // Drive latch: full-word writes to the register and both aliases
   drive_set_a: assert property (wr_en && sel == SEL_DRIVE_SET && PSTRB == 4'hF
      |=> PIN_OUT == ($past(drive_ff) | $past(PWDATA)))
      else $error("drive set alias wrong");
   drive_clr_a: assert property (wr_en && sel == SEL_DRIVE_CLEAR && PSTRB == 4'hF
      |=> PIN_OUT == ($past(drive_ff) & ~$past(PWDATA)))
      else $error("drive clear alias wrong");
   drive_wr_a: assert property (wr_en && sel == SEL_DRIVE_LEVEL && PSTRB == 4'hF
      |=> PIN_OUT == $past(PWDATA))
      else $error("drive write not applied");
   // Aliases under any strobe: written ones act, every other bit keeps
   set_ones_a: assert property (wr_en && sel == SEL_DRIVE_SET
      |=> (PIN_OUT & $past(wbits)) == $past(wbits))
      else $error("drive set alias missed a bit");
   set_keep_a: assert property (wr_en && sel == SEL_DRIVE_SET
      |=> (PIN_OUT & ~$past(wbits)) == ($past(drive_ff) & ~$past(wbits)))
      else $error("drive set alias touched a zero bit");
   clr_zero_a: assert property (wr_en && sel == SEL_DRIVE_CLEAR
      |=> (PIN_OUT & $past(wbits)) == 32'h0000_0000)
      else $error("drive clear alias missed a bit");
   clr_keep_a: assert property (wr_en && sel == SEL_DRIVE_CLEAR
      |=> (PIN_OUT & ~$past(wbits)) == ($past(drive_ff) & ~$past(wbits)))
      else $error("drive clear alias touched a zero bit");

   // Latches move only on a write that addresses them
   drive_hold_a: assert property (!(wr_en && (sel == SEL_DRIVE_LEVEL
      || sel == SEL_DRIVE_SET || sel == SEL_DRIVE_CLEAR)) |=> $stable(drive_ff))
      else $error("drive latch changed without a write");
   orient_hold_a: assert property (!(wr_en && (sel == SEL_ORIENT
      || sel == SEL_ORIENT_SET)) |=> $stable(orient_ff))
      else $error("orientation latch changed without a write");
   level_ro_a: assert property (wr_en && sel == SEL_LEVEL_READ
      |=> $stable(drive_ff) && $stable(orient_ff))
      else $error("write to level register had an effect");

   // Read data: loaded at the setup edge, shown during the access cycle.
   // Outside a read setup the word must not move, or a slow master that
   // samples late would see a different value than a fast one.
   alias_rd_a: assert property (PSEL && !PENABLE && !PWRITE
      && (sel == SEL_DRIVE_SET || sel == SEL_DRIVE_CLEAR) && !wr_en
      |=> PRDATA == drive_ff)
      else $error("drive alias read mismatch");
   drive_rd_a: assert property (rd_setup && sel == SEL_DRIVE_LEVEL
      |=> PRDATA == $past(drive_ff))
      else $error("drive read mismatch");
   level_rd_a: assert property (PSEL && !PENABLE && !PWRITE && sel == SEL_LEVEL_READ
      |=> PRDATA == $past(level_ff))
      else $error("level read mismatch");
   orient_rd_a: assert property (PSEL && !PENABLE && !PWRITE && sel == SEL_ORIENT_SET
      && !wr_en |=> PRDATA == orient_ff)
      else $error("orientation alias read mismatch");
   orient_plain_rd_a: assert property (rd_setup && sel == SEL_ORIENT
      |=> PRDATA == $past(orient_ff))
      else $error("orientation read mismatch");
   prdata_hold_a: assert property (!rd_setup |=> $stable(PRDATA))
      else $error("read data changed outside a read setup");

   // Pins: a steady input shows in the level register after three edges
   level_lat_a: assert property ($stable(PIN_IN) [*4]
      |-> level_ff == PIN_IN)
      else $error("pin level not tracked");
   orient_wr_a: assert property (wr_en && sel == SEL_ORIENT && PSTRB == 4'hF
      |=> PIN_OE_N == ~$past(PWDATA))
      else $error("orientation write not applied");
   orient_set_a: assert property (wr_en && sel == SEL_ORIENT_SET && PSTRB == 4'hF
      |=> orient_ff == ($past(orient_ff) | $past(PWDATA)))
      else $error("orientation set alias wrong");
   orient_keep_a: assert property (wr_en && sel == SEL_ORIENT_SET
      |=> (orient_ff & $past(orient_ff)) == $past(orient_ff))
      else $error("orientation set alias cleared a bit");
   // A pin may start to drive only the cycle after an orientation write;
   // anything else turning a driver on would fight the outside circuit
   no_drive_a: assert property (|($past(PIN_OE_N) & ~PIN_OE_N)
      |-> $past(wr_en) && ($past(sel) == SEL_ORIENT || $past(sel) == SEL_ORIENT_SET))
      else $error("pin driven without an orientation write");

   // Per byte lane: a lane whose strobe is low is never touched by a
   // write, whichever register or alias the write addresses
   for (genvar gl = 0; gl < 4; gl++) begin : g_lane
      lane_drv_a: assert property (wr_en && !PSTRB[gl]
         |=> $stable(drive_ff[8*gl +: 8]))
         else $error("masked lane of drive latch changed");
      lane_dir_a: assert property (wr_en && !PSTRB[gl]
         |=> $stable(orient_ff[8*gl +: 8]))
         else $error("masked lane of orientation latch changed");
   end

   // Main scenarios that a run should reach
   set_then_clr_c: cover property (wr_en && sel == SEL_DRIVE_SET
      ##[1:4] wr_en && sel == SEL_DRIVE_CLEAR);
   orient_set_c: cover property (wr_en && sel == SEL_ORIENT_SET && PWDATA != 32'h0);
   level_read_c: cover property (rd_en && sel == SEL_LEVEL_READ && PRDATA != 32'h0);
   unmapped_c: cover property (rd_en && sel == SEL_NONE);
   strobe_write_c: cover property (wr_en && PSTRB != 4'hF);
endmodule : gpd_port

// File: logic/gpd_sync.sv
/*
   Two-stage synchroniser for a vector of pin inputs.
   Assumes the pins are asynchronous to CLK.
*/
module gpd_sync
   import gpd_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [PIN_COUNT-1:0] D,
   output logic [PIN_COUNT-1:0] Q
);
   logic [PIN_COUNT-1:0] meta_ff;
   logic [PIN_COUNT-1:0] sync_ff;
   logic [PIN_COUNT-1:0] nxt_meta;
   logic [PIN_COUNT-1:0] nxt_sync;

   // First stage feeds only the second stage
   always_comb begin
      nxt_meta = D;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         meta_ff <= RST_PORT_LEVEL_READ;
         sync_ff <= RST_PORT_LEVEL_READ;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign Q = sync_ff;
endmodule : gpd_sync

// File: tb/gpd_pads.sv
/* Pad ring model for gpd_port: resolves each pin from the block's
   driver and an outside source. Assumes one outside level per pin. */
module gpd_pads
   import gpd_pkg::*;
(
   input wire logic [PIN_COUNT-1:0] ext_lvl,
   input wire logic [PIN_COUNT-1:0] pin_out,
   input wire logic [PIN_COUNT-1:0] pin_oe_n,
   output logic [PIN_COUNT-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------
   // Pin resolution
   // ------------------------------------------
   // Outside circuit yields to the block wherever it drives
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
endmodule : gpd_pads

// File: tb/test_gpio_port_drive_direction_regs.sv
/* Bench for gpd_port: table of register accesses, then pin, strobe
   and reset cases. Assumes gpd_pads on the pins. */
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
module test_gpio_port_drive_direction_regs import gpd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d;} gpd_row_t;
   logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] pwdata = 32'h0, prdata, rd, pin_in, pin_out, pin_oe_n;
   logic [31:0] ext_lvl = 32'h1234_5678;
   int errors = 0, tests_run = 0, cyc = 0;
   // Reads carry expected data, writes carry write data
   gpd_row_t rows[12] = '{'{1'b0, 12'h504, 32'h0}, '{1'b1, 12'h504, 32'hA5A5_A5A5},
      '{1'b1, 12'h508, 32'h0F0F_0000}, '{1'b0, 12'h508, 32'hAFAF_A5A5},
      '{1'b1, 12'h50C, 32'h0000_00FF}, '{1'b0, 12'h50C, 32'hAFAF_A500},
      '{1'b1, 12'h514, 32'h0000_FFFF}, '{1'b1, 12'h518, 32'hFF00_0000},
      '{1'b1, 12'h510, 32'hFFFF_FFFF}, '{1'b0, 12'h518, 32'hFF00_FFFF},
      '{1'b0, 12'h514, 32'hFF00_FFFF}, '{1'b0, 12'h51C, 32'h0}};
   gpd_port dut_u (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in),
      .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n));
   gpd_pads pads_u (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_in(pin_in));
   // ------------------------------------------
   // Clock, timeout and closing report
   // ------------------------------------------
   initial begin
      forever #10 clk = ~clk;
   end
   // Run needs well under 300 cycles; a hung wait ends here
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] q);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      `CHK("oe_n at reset", 32'hFFFF_FFFF, pin_oe_n)
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d, 4'hF, rd);
         if (!rows[i].wr) `CHK("row read", rows[i].d, rd)
         `CHK("pslverr", 1'b0, pslverr)
      end
      @(posedge clk);
      `CHK("pin_out", 32'hAFAF_A500, pin_out)
      `CHK("pin_oe_n", 32'h00FF_0000, pin_oe_n)
      // Input pins follow the outside level, output pins the drive latch
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h510, 32'h0, 4'hF, rd);
      `CHK("level read", 32'hAF34_A500, rd)
      // Only the low lane is enabled, so only bits 7:0 may be set
      apb(1'b1, 12'h508, 32'hFFFF_FFFF, 4'h1, rd);
      apb(1'b0, 12'h504, 32'h0, 4'hF, rd);
      `CHK("strobed set", 32'hAFAF_A5FF, rd)
      // Reset in mid-run returns every latch to zero
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("pin_out in reset", 32'h0, pin_out)
      sys_rst <= 1'b0;
      apb(1'b0, 12'h514, 32'h0, 4'hF, rd);
      `CHK("orientation after reset", 32'h0, rd)
      end_of_test();
   end
endmodule : test_gpio_port_drive_direction_regs
